// ===== rtl/asct_pkg.sv
// Package for the asynchronous SRAM host controller: timing, pin and request types
package asct_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned ADDR_W        = 20;
  localparam int unsigned DATA_W        = 16;

  // Figures in ns as specified for the memory
  localparam int unsigned T_CYCLE_NS    = 45;   // Read and write cycle time
  localparam int unsigned T_WR_PULSE_NS = 35;   // Select, lane and strobe active to write end
  localparam int unsigned T_DSETUP_NS   = 25;   // Data setup to write end
  localparam int unsigned T_HZWE_NS     = 18;   // Strobe low to memory bus release
  localparam int unsigned T_ACCESS_NS   = 45;   // Address or select to read data valid
  localparam int unsigned T_HZ_NS       = 18;   // Enable high to memory bus release

  // Least times round up to whole cycles
  localparam int unsigned CYC_CYCLE    = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_WR_PULSE_BASE =
    (T_WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_WR_OE_LOW =
    (T_DSETUP_NS + T_HZWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_WR_PULSE =
    (CYC_WR_OE_LOW > CYC_WR_PULSE_BASE) ? CYC_WR_OE_LOW : CYC_WR_PULSE_BASE;
  localparam int unsigned CYC_DSETUP   = (T_DSETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_ACCESS   = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CYC_TURN     = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned CNT_W = 4;

  // Idle levels of the control pins
  localparam logic SEL_LOW_IDLE  = 1'b1;
  localparam logic SEL_HIGH_IDLE = 1'b0;

  // Pins driven toward the memory
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              select_low_active;
    logic              select_high_active;
    logic              write_strobe_n;
    logic              output_drive_n;
    logic              upper_lane_enable_n;
    logic              lower_lane_enable_n;
    logic [DATA_W-1:0] data_out;
    logic              data_oe;
  } asct_pins_t;

  // Request from the user side
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        lanes;   // Bit 1 upper, bit 0 lower; active high
  } asct_req_t;

endpackage : asct_pkg

// ===== rtl/asct_cycle_timer.sv
// Down counter that times each phase of a memory cycle except the one-cycle write setup
`timescale 1ns/10ps
module asct_cycle_timer
  import asct_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_W
) (
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] value_i,
  output logic                  done_o
);

  logic [WIDTH-1:0] count_q;

  // Load wins over counting so a new phase always starts fresh
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_q <= '0;
    end else if (load_i) begin
      count_q <= value_i;
    end else if (count_q != '0) begin
      count_q <= count_q - WIDTH'(1);
    end
  end

  assign done_o = (count_q == '0);

endmodule : asct_cycle_timer

// ===== rtl/asct_sram_host.sv
// Host controller that runs read and write cycles on an asynchronous 16-bit SRAM
// Function
// R1 - Memory writes only while strobe, low select, a lane low and high select high.
// R2 - Memory ends write when any participating signal goes inactive.
// R3 - Setup and hold are measured against the edge that ends the write.
// R4 - Address stable when write starts and at least 35 ns before its end.
// R5 - Address may change right after the write ends.
// R6 - Selects, lanes and strobe active at least 35 ns before write end.
// R7 - Write data valid at least 25 ns before write end, zero hold.
// R8 - Strobe pulse with output drive enabled lasts data setup plus bus release.
// R9 - Memory releases bus within 18 ns of strobe low, drives 10 ns after rise.
// R10 - Memory keeps bus high impedance during a write with output drive high.
// R11 - Controller never drives the bus while the memory still drives it.
// R12 - Both selects dropping together with strobe high leaves bus released.
// R13 - Strobe stays high through every read cycle.
// R14 - Read data valid within 45 ns of address or select.
// R15 - Previous data held at least 10 ns after an address change.
// R16 - Read data within 22 ns of output enable low, drive after 5 ns.
// R17 - Lane data within 45 ns of lane enable low, drive after 10 ns.
// R18 - Memory releases bus within 18 ns of any enable going inactive.
// R19 - Memory release time is always shorter than its drive-start time.
// R20 - For output-enable reads, address valid no later than selects and lanes.
// R21 - Deselect by dropping a chip select or raising both lane enables.
// R22 - Each read or write cycle lasts at least 45 ns to the next start.
`timescale 1ns/10ps
module asct_sram_host
  import asct_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  input  wire logic              req_valid_i,
  input  wire asct_req_t         req_i,
  output logic                   req_ready_o,
  output logic                   rdata_valid_o,
  output logic [DATA_W-1:0]      rdata_o,
  output asct_pins_t             pins_o,
  input  wire logic [DATA_W-1:0] data_in_i
);

  // Phases of one memory cycle; every cycle ends in ASCT_TURN
  typedef enum logic [2:0] {
    ASCT_IDLE,
    ASCT_WR_SETUP,
    ASCT_WR_PULSE,
    ASCT_RD_ACCESS,
    ASCT_TURN
  } asct_state_t;

  // Whole controller state, registered as one word
  typedef struct packed {
    asct_state_t       state;
    asct_pins_t        pins;
    logic              ready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
  } asct_regs_t;

  asct_regs_t       r_q;
  asct_regs_t       r_d;
  logic             tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic             tmr_done;
  logic             take;
  logic [1:0]       lane_req_n;

  // A request is taken only on an edge where the controller shows ready
  assign take = req_valid_i && r_q.ready;

  // Requested byte lanes as active-low pin levels, one per lane
  for (genvar g = 0; g < 2; g++) begin : g_lane
    // A lane left out of the request stays disabled, so its byte is untouched
    assign lane_req_n[g] = ~req_i.lanes[g];
  end : g_lane

  // One timer serves every phase but ASCT_WR_SETUP, which always lasts one cycle; phases never overlap
  // Its done flag is acted on one edge after zero, so a phase lasts its load plus one
  asct_cycle_timer #(
    .WIDTH (CNT_W)
  ) u_timer (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .load_i  (tmr_load),
    .value_i (tmr_value),
    .done_o  (tmr_done)
  );

  // Pins at rest: deselected, strobe and output drive high, bus released
  // Both selects drop in one edge with the strobe high, so the bus stays released
  function automatic asct_pins_t idle_pins(input asct_pins_t p);
    asct_pins_t o;
    o                     = p;
    o.select_low_active   = SEL_LOW_IDLE;   // see R21
    o.select_high_active  = SEL_HIGH_IDLE;
    o.write_strobe_n      = 1'b1;
    o.output_drive_n      = 1'b1;
    o.upper_lane_enable_n = 1'b1;
    o.lower_lane_enable_n = 1'b1;
    o.data_oe             = 1'b0;
    return o;
  endfunction : idle_pins

  // Pins that open a cycle: address, lanes and both selects in one edge, so the
  // address is never later than the selects; strobe stays high until the
  // write's own phase, and output drive falls only for a read
  function automatic asct_pins_t start_pins(input asct_pins_t p,
                                            input asct_req_t  rq,
                                            input logic [1:0] lane_n);
    asct_pins_t o;
    o                     = p;
    o.addr                = rq.addr;          // see R4 see R20
    o.upper_lane_enable_n = lane_n[1];
    o.lower_lane_enable_n = lane_n[0];
    o.select_low_active   = 1'b0;
    o.select_high_active  = 1'b1;
    o.write_strobe_n      = 1'b1;             // see R13
    o.output_drive_n      = rq.write;         // see R10 see R11
    o.data_out            = rq.write ? rq.wdata : p.data_out;
    o.data_oe             = 1'b0;
    return o;
  endfunction : start_pins

  // Next-state logic for the whole controller.
  // Write: selects first, strobe low for the full pulse with data driven, strobe up.
  // Read: selects and output drive together, data taken when the access count ends.
  // Both end in ASCT_TURN; a read rests its pins a cycle before ready, a write rests them on the edge that raises ready.
  always_comb begin
    r_d       = r_q;
    tmr_load  = 1'b0;
    tmr_value = '0;
    r_d.rvalid = 1'b0;
    case (r_q.state)
      ASCT_IDLE: begin
        if (take) begin
          r_d.ready = 1'b0;
          // All opening pins change on the same edge
          r_d.pins  = start_pins(r_q.pins, req_i, lane_req_n);
          if (req_i.write) begin
            // Output drive stays high, so the memory never drives during a write
            r_d.state = ASCT_WR_SETUP;
          end else begin
            // Access count starts with the selects, the latest of the read's edges
            tmr_load  = 1'b1;
            tmr_value = CNT_W'(CYC_ACCESS);  // see R14 see R16 see R17
            r_d.state = ASCT_RD_ACCESS;
          end
        end
      end
      ASCT_WR_SETUP: begin
        // Address settled one cycle before the strobe falls
        // Output drive is high, so driving data now cannot contend
        r_d.pins.write_strobe_n = 1'b0;       // see R1
        r_d.pins.data_oe        = 1'b1;       // see R11
        tmr_load  = 1'b1;
        tmr_value = CNT_W'(CYC_WR_PULSE - 1); // see R6 see R8 see R22
        r_d.state = ASCT_WR_PULSE;
      end
      ASCT_WR_PULSE: begin
        if (tmr_done) begin
          // Strobe alone ends the write; data and address held to that same edge
          r_d.pins.write_strobe_n = 1'b1;     // see R2 see R3 see R7 see R5
          r_d.state = ASCT_TURN;
          tmr_load  = 1'b1;
          tmr_value = CNT_W'(0);
        end
      end
      ASCT_RD_ACCESS: begin
        if (tmr_done) begin
          // Full access count runs, one cycle of margin over the access time
          r_d.rdata  = data_in_i;             // see R14
          r_d.rvalid = 1'b1;
          r_d.pins   = idle_pins(r_q.pins);   // see R21
          tmr_load   = 1'b1;
          // Memory release takes up to one more cycle before the next access
          tmr_value  = CNT_W'(CYC_TURN - 1);  // see R18 see R19
          r_d.state  = ASCT_TURN;
        end
      end
      ASCT_TURN: begin
        // Pins at rest; ready returns as the count runs out
        r_d.pins = idle_pins(r_q.pins);
        if (tmr_done) begin
          r_d.ready = 1'b1;
          r_d.state = ASCT_IDLE;
        end
      end
      default: begin
        // Unknown state falls back to rest
        r_d.pins  = idle_pins(r_q.pins);
        r_d.ready = 1'b1;
        r_d.state = ASCT_IDLE;
      end
    endcase
  end

  // State register; pins idle and bus released under reset
  // Reset values are spelled out field by field as constants
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_q.state                    <= ASCT_IDLE;
      r_q.pins.addr                <= '0;
      r_q.pins.select_low_active   <= SEL_LOW_IDLE;
      r_q.pins.select_high_active  <= SEL_HIGH_IDLE;
      r_q.pins.write_strobe_n      <= 1'b1;
      r_q.pins.output_drive_n      <= 1'b1;
      r_q.pins.upper_lane_enable_n <= 1'b1;
      r_q.pins.lower_lane_enable_n <= 1'b1;
      r_q.pins.data_out            <= '0;
      r_q.pins.data_oe             <= 1'b0;
      r_q.ready                    <= 1'b1;
      r_q.rvalid                   <= 1'b0;
      r_q.rdata                    <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs come straight from the state register
  assign pins_o        = r_q.pins;
  assign req_ready_o   = r_q.ready;
  assign rdata_valid_o = r_q.rvalid;
  assign rdata_o       = r_q.rdata;

endmodule : asct_sram_host

// ===== tb/asct_sram_model.sv
// Behavioural model of the asynchronous 16-bit SRAM seen at its pins
`timescale 1ns/10ps
module asct_sram_model
  import asct_pkg::*;
#(
  parameter int unsigned ACCESS_NS = 40
) (
  input  wire asct_pins_t   pins_i,
  output logic [DATA_W-1:0] data_o
);
  logic [DATA_W-1:0] mem [256];
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] bus;
  wire logic sel   = !pins_i.select_low_active && pins_i.select_high_active;
  wire logic lanes = !(pins_i.upper_lane_enable_n && pins_i.lower_lane_enable_n);
  wire logic wr_on = sel && lanes && !pins_i.write_strobe_n;
  wire logic rd_on = sel && pins_i.write_strobe_n && !pins_i.output_drive_n;
  // Lanes take the data when the overlap closes, unless raising the lane enables is what closes it
  always @(negedge wr_on) begin
    if (!pins_i.upper_lane_enable_n) mem[pins_i.addr[7:0]][15:8] = pins_i.data_out[15:8];
    if (!pins_i.lower_lane_enable_n) mem[pins_i.addr[7:0]][7:0] = pins_i.data_out[7:0];
  end
  // A released lane shows the inverse, so stale sampling never passes
  always @* begin
    q = mem[pins_i.addr[7:0]];
    bus[15:8] = (rd_on && !pins_i.upper_lane_enable_n) ? q[15:8] : ~q[15:8];
    bus[7:0] = (rd_on && !pins_i.lower_lane_enable_n) ? q[7:0] : ~q[7:0];
  end
  // One delay for drive and release keeps a slow but legal answer
  assign #(ACCESS_NS) data_o = bus;
endmodule : asct_sram_model

// ===== tb/asct_sram_host_chk.sv
// Checker of the host pin sequencing of the SRAM controller
`timescale 1ns/10ps
module asct_sram_host_chk
  import asct_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              rst_b_i,
  input wire logic              req_valid_i,
  input wire asct_req_t         req_i,
  input wire logic              req_ready_o,
  input wire logic              rdata_valid_o,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire asct_pins_t        pins_o,
  input wire logic [DATA_W-1:0] data_in_i
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire logic sel = !pins_o.select_low_active && pins_o.select_high_active;
  wire logic we_n = pins_o.write_strobe_n;
  sequence s_take; req_valid_i && req_ready_o; endsequence
  sequence s_read_take; s_take ##0 !req_i.write; endsequence
  sequence s_pulse_open; $fell(we_n); endsequence
  cycle_gap_a: assert property (s_take |=> !req_ready_o [*2])
    else $error("cycle shorter than allowed");
  read_answer_a: assert property (s_read_take |-> ##5 rdata_valid_o)
    else $error("read data not returned in time");
  pulse_width_a: assert property (s_pulse_open |-> !we_n [*3])
    else $error("strobe pulse too short");
  strobe_sel_a: assert property (!we_n |-> sel && pins_o.output_drive_n)
    else $error("strobe low while deselected");
  addr_hold_a: assert property (sel && $past(sel) |-> $stable(pins_o.addr))
    else $error("address moved while selected");
  data_setup_a: assert property ($rose(we_n) |-> sel && $past(pins_o.data_oe, 2))
    else $error("write end without data setup");
  no_contend_a: assert property (pins_o.data_oe |-> pins_o.output_drive_n)
    else $error("host drives during read");
  read_strobe_a: assert property (!pins_o.output_drive_n |-> we_n)
    else $error("strobe low during read");
  turnaround_a: assert property ($rose(pins_o.output_drive_n) |-> !pins_o.data_oe [*2])
    else $error("no bus turnaround");
  rdata_take_a: assert property (rdata_valid_o |-> rdata_o == $past(data_in_i))
    else $error("read data not the sampled bus");
  idle_deselect_a: assert property (req_ready_o |-> !sel)
    else $error("memory selected while idle");
endmodule : asct_sram_host_chk
bind asct_sram_host asct_sram_host_chk u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
  .rdata_valid_o(rdata_valid_o), .rdata_o(rdata_o), .pins_o(pins_o), .data_in_i(data_in_i));

// ===== tb/asct_sram_host_tb_top.sv
// Self-checking bench for the SRAM host controller
`timescale 1ns/10ps
module asct_sram_host_tb_top
  import asct_pkg::*;
;
  logic              clock_i = 1'b0;
  logic              rst_b_i = 1'b0;
  logic              req_valid = 1'b0;
  asct_req_t         req = '0;
  logic              ready;
  logic              rvalid;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] din;
  asct_pins_t        pins;
  int                num_errors = 0;
  int                tests_run = 0;
  int                cyc = 0;
  always #10 clock_i = ~clock_i;
  asct_sram_host uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid),
    .req_i(req), .req_ready_o(ready), .rdata_valid_o(rvalid), .rdata_o(rdata),
    .pins_o(pins), .data_in_i(din));
  asct_sram_model #(.ACCESS_NS(40)) u_mem (.pins_i(pins), .data_o(din));
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  // One request, entered at an edge; a read answer is launched four edges after its take
  task automatic xfer(input logic wr, input logic [19:0] a, input logic [15:0] d,
                      input logic [1:0] ln, output logic [15:0] q);
    req_valid <= 1'b1;
    req <= '{write: wr, addr: a, wdata: d, lanes: ln};
    do @(posedge clock_i); while (ready !== 1'b1);
    req_valid <= 1'b0;
    repeat (4) @(posedge clock_i);
    #1;
    q = rdata;
    check({15'h0, rvalid}, {15'h0, !wr});
    while (ready !== 1'b1) @(posedge clock_i);
  endtask : xfer
  // Idle pins: deselected, strobe and output drive high, bus not driven
  task automatic t_idle;
    check({9'h0, pins.select_low_active, pins.select_high_active, pins.write_strobe_n,
      pins.output_drive_n, pins.upper_lane_enable_n, pins.lower_lane_enable_n,
      pins.data_oe}, 16'h005e);
    $display("test idle done");
  endtask : t_idle
  // Writes back to back, then read each word back
  task automatic t_rw;
    logic [15:0] q;
    for (int i = 0; i < 3; i++) xfer(1'b1, 20'h00010 + 20'(i), 16'ha5c3 ^ 16'(i), 2'b11, q);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, 20'h00010 + 20'(i), 16'h0000, 2'b11, q);
      check(q, 16'ha5c3 ^ 16'(i));
    end
    $display("test write read done");
  endtask : t_rw
  // Every lane code; no lanes leaves the word alone
  task automatic t_lanes;
    logic [15:0] q;
    for (int l = 0; l < 4; l++) begin
      xfer(1'b1, 20'h00040 + 20'(l), 16'hffff, 2'b11, q);
      xfer(1'b1, 20'h00040 + 20'(l), 16'h1234, 2'(l), q);
      xfer(1'b0, 20'h00040 + 20'(l), 16'h0000, 2'b11, q);
      check(q, {l[1] ? 8'h12 : 8'hff, l[0] ? 8'h34 : 8'hff});
    end
    $display("test lanes done");
  endtask : t_lanes
  // Run time ceiling
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge clock_i);
    t_idle();
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    t_rw();
    t_lanes();
    t_idle();
    summarize();
  end
endmodule : asct_sram_host_tb_top
